//--- qfs_pkg.sv
// constants, input map and state type for the flyback control sequencer
// Notes on behaviour
// - ignore the current-limit comparator for 300 ns after every gate turn-on.
// - no turn-on at time-out expiry while secondary current is still flowing.
// - next turn-on only after the aux sense drop shows zero secondary current.
// - conduction-mode prevention may stretch the period below the minimum frequency.
// - time-out window equals the 21.5 kHz minimum boundary-mode frequency period.
// - at supply turn-on level, stop the startup source and sample the bulk.
// - bulk above brown-in starts switching, otherwise enter auto-restart unswitched.
// - keep the startup source off for as long as switching runs.
// - feedback below the burst stop level stops gate pulses.
// - while burst-stopped, feedback above the resume level restarts switching.
// - feedback below the minimum-peak level clamps each pulse at minimum peak.
// - the minimum peak threshold comes from a fixed trim, not runtime control.
// - feedback below the stop level over 100 us enters standby supply current.
// - feedback above the resume level leaves standby and resumes switching.
// - supply overvoltage, abnormal overcurrent or thermal fault ends switching, gate off.
// - supply at turn-off level during auto-restart clears protection, starts recharge.
// - supply back at turn-on level resumes operation; repeats while the fault stays.
// - output over/under-voltage suppresses switching for 3 (low line) or 6 cycles.
// - no latched protection; every fault recovers through auto-restart.
// - line flag goes high above 1.440 mA, low below 1.350 mA.
package qfs_pkg;

    localparam int unsigned CLK_MHZ         = 125;
    localparam int unsigned CLK_HZ          = 125000000;
    localparam int unsigned LEB_NS          = 300;
    localparam int unsigned TIMEOUT_FREQ_HZ = 21500;
    localparam int unsigned STANDBY_US      = 100;

    // least times: round up to whole cycles
    localparam logic [5:0]  LEB_CYC     = 6'((LEB_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] TIMEOUT_CYC =
        16'((CLK_HZ + TIMEOUT_FREQ_HZ - 1) / TIMEOUT_FREQ_HZ);
    localparam logic [15:0] STANDBY_CYC = 16'(STANDBY_US * CLK_MHZ);

    localparam logic [2:0]  AR_LOW_LINE  = 3'h3;
    localparam logic [2:0]  AR_HIGH_LINE = 3'h6;
    localparam logic [2:0]  AR_SINGLE    = 3'h1;

    localparam logic [1:0]  TRIM_RESET  = 2'h0;

    localparam int unsigned N_IN        = 17;
    localparam int unsigned IN_ILIM     = 0;
    localparam int unsigned IN_PEAK     = 1;
    localparam int unsigned IN_CSMIN    = 2;
    localparam int unsigned IN_AUX      = 3;
    localparam int unsigned IN_VDD_ON   = 4;
    localparam int unsigned IN_VDD_OFF  = 5;
    localparam int unsigned IN_BULK     = 6;
    localparam int unsigned IN_FB_STOP  = 7;
    localparam int unsigned IN_FB_RES   = 8;
    localparam int unsigned IN_FB_MIN   = 9;
    localparam int unsigned IN_SUPPLY_OVERVOLTAGE_FAULT  = 10;
    localparam int unsigned IN_ABNORMAL_OVERCURRENT_FAULT     = 11;
    localparam int unsigned IN_TSD      = 12;
    localparam int unsigned IN_OUT_OVP  = 13;
    localparam int unsigned IN_OUT_UVP  = 14;
    localparam int unsigned IN_LINE_HI  = 15;
    localparam int unsigned IN_LINE_LO  = 16;

    typedef enum logic [1:0] {
        ST_CHARGE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_RUN    = 2'b10,
        ST_DISCH  = 2'b11
    } qfs_state_t;

endpackage : qfs_pkg

//--- qfs_sync.sv
// three-flop synchroniser bank for the analog comparator outputs
module qfs_sync (
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic [qfs_pkg::N_IN-1:0] async_in,
    output logic      [qfs_pkg::N_IN-1:0] sync_out
);
    import qfs_pkg::*;

    logic [N_IN-1:0] s1_q;
    logic [N_IN-1:0] s2_q;
    logic [N_IN-1:0] s3_q;

    for (genvar i = 0; i < N_IN; i++) begin : g_bit
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                s1_q[i]     <= 1'b0;
                s2_q[i]     <= 1'b0;
                s3_q[i]     <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                s1_q[i] <= async_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                // a change only counts once two stages agree
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end

endmodule : qfs_sync

//--- qfs_sequencer.sv
// flyback control sequencer: gate timing, startup, burst, auto-restart
module qfs_sequencer #(
    parameter logic [15:0] TIMEOUT_CYC = qfs_pkg::TIMEOUT_CYC,
    parameter logic [15:0] STANDBY_CYC = qfs_pkg::STANDBY_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       current_limit_cmp,
    input  wire logic       peak_reached_cmp,
    input  wire logic       min_peak_reached_cmp,
    input  wire logic       aux_sense_input,
    input  wire logic       supply_turn_on_level,
    input  wire logic       supply_turn_off_level,
    input  wire logic       bulk_above_brown_in,
    input  wire logic       burst_stop_level,
    input  wire logic       burst_resume_level,
    input  wire logic       fb_below_min_peak,
    input  wire logic       supply_overvoltage_fault,
    input  wire logic       abnormal_overcurrent_fault,
    input  wire logic       thermal_shutdown_fault,
    input  wire logic       output_overvoltage_fault,
    input  wire logic       output_undervoltage_fault,
    input  wire logic       high_line_entry_current,
    input  wire logic       low_line_entry_current,
    input  wire logic [1:0] min_peak_trim,
    output logic            gate_drive_q,
    output logic            hv_start_enable_q,
    output logic            bulk_sample_enable_q,
    output logic            min_peak_clamp_q,
    output logic [1:0]      min_peak_sel_q,
    output logic            standby_current_q,
    output logic            high_line_q,
    output logic            burst_stop_q,
    output logic            protect_active_q
);
    import qfs_pkg::*;

    logic [N_IN-1:0] cmp_raw;
    logic [N_IN-1:0] cmp_s;

    assign cmp_raw[IN_ILIM]    = current_limit_cmp;
    assign cmp_raw[IN_PEAK]    = peak_reached_cmp;
    assign cmp_raw[IN_CSMIN]   = min_peak_reached_cmp;
    assign cmp_raw[IN_AUX]     = aux_sense_input;
    assign cmp_raw[IN_VDD_ON]  = supply_turn_on_level;
    assign cmp_raw[IN_VDD_OFF] = supply_turn_off_level;
    assign cmp_raw[IN_BULK]    = bulk_above_brown_in;
    assign cmp_raw[IN_FB_STOP] = burst_stop_level;
    assign cmp_raw[IN_FB_RES]  = burst_resume_level;
    assign cmp_raw[IN_FB_MIN]  = fb_below_min_peak;
    assign cmp_raw[IN_SUPPLY_OVERVOLTAGE_FAULT] = supply_overvoltage_fault;
    assign cmp_raw[IN_ABNORMAL_OVERCURRENT_FAULT]    = abnormal_overcurrent_fault;
    assign cmp_raw[IN_TSD]     = thermal_shutdown_fault;
    assign cmp_raw[IN_OUT_OVP] = output_overvoltage_fault;
    assign cmp_raw[IN_OUT_UVP] = output_undervoltage_fault;
    assign cmp_raw[IN_LINE_HI] = high_line_entry_current;
    assign cmp_raw[IN_LINE_LO] = low_line_entry_current;

    // every comparator is asynchronous to clk_sys
    qfs_sync u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in (cmp_raw),
        .sync_out (cmp_s)
    );

    logic ilim_s;
    logic peak_s;
    logic csmin_s;
    logic aux_s;
    logic vdd_on_s;
    logic vdd_off_s;
    logic bulk_s;
    logic fb_stop_s;
    logic fb_res_s;
    logic fb_min_s;
    logic fault_ar;
    logic fault_out;

    assign ilim_s    = cmp_s[IN_ILIM];
    assign peak_s    = cmp_s[IN_PEAK];
    assign csmin_s   = cmp_s[IN_CSMIN];
    assign aux_s     = cmp_s[IN_AUX];
    assign vdd_on_s  = cmp_s[IN_VDD_ON];
    assign vdd_off_s = cmp_s[IN_VDD_OFF];
    assign bulk_s    = cmp_s[IN_BULK];
    assign fb_stop_s = cmp_s[IN_FB_STOP];
    assign fb_res_s  = cmp_s[IN_FB_RES];
    assign fb_min_s  = cmp_s[IN_FB_MIN];
    assign fault_ar  = cmp_s[IN_SUPPLY_OVERVOLTAGE_FAULT] | cmp_s[IN_ABNORMAL_OVERCURRENT_FAULT] | cmp_s[IN_TSD];
    assign fault_out = cmp_s[IN_OUT_OVP] | cmp_s[IN_OUT_UVP];

    qfs_state_t state_q;
    qfs_state_t state_d;
    logic [2:0] ar_cnt_q;
    logic [2:0] ar_cnt_d;

    // supervisor; ar_cnt holds how many discharge cycles remain unswitched.
    // nothing here latches: every path leads back through ST_CHARGE
    always_comb begin
        state_d  = state_q;
        ar_cnt_d = ar_cnt_q;
        unique case (state_q)
            ST_CHARGE: begin
                if (vdd_on_s) begin
                    // suppressed cycles discharge again without sampling
                    state_d = (ar_cnt_q == 3'h0) ? ST_SAMPLE : ST_DISCH;
                end
            end
            ST_SAMPLE: begin
                if (bulk_s) begin
                    state_d = ST_RUN;
                end else begin
                    state_d  = ST_DISCH;
                    ar_cnt_d = AR_SINGLE;
                end
            end
            ST_RUN: begin
                if (fault_out) begin
                    state_d  = ST_DISCH;
                    ar_cnt_d = high_line_q ? AR_HIGH_LINE : AR_LOW_LINE;
                end else if (fault_ar) begin
                    state_d  = ST_DISCH;
                    ar_cnt_d = AR_SINGLE;
                end else if (vdd_off_s) begin
                    state_d  = ST_CHARGE;
                    ar_cnt_d = 3'h0;
                end
            end
            ST_DISCH: begin
                if (vdd_off_s) begin
                    state_d = ST_CHARGE;
                    if (ar_cnt_q != 3'h0) begin
                        ar_cnt_d = ar_cnt_q - 3'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q  <= ST_CHARGE;
            ar_cnt_q <= 3'h0;
        end else begin
            state_q  <= state_d;
            ar_cnt_q <= ar_cnt_d;
        end
    end

    // supply-side outputs follow the next state so they line up with state_q
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hv_start_enable_q    <= 1'b1;
            bulk_sample_enable_q <= 1'b0;
            protect_active_q     <= 1'b0;
        end else begin
            hv_start_enable_q    <= (state_d == ST_CHARGE);
            bulk_sample_enable_q <= (state_d == ST_SAMPLE);
            protect_active_q     <= (state_d == ST_DISCH);
        end
    end

    // line flag with hysteresis between the two current comparators
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            high_line_q <= 1'b0;
        end else if (cmp_s[IN_LINE_HI]) begin
            high_line_q <= 1'b1;
        end else if (cmp_s[IN_LINE_LO]) begin
            high_line_q <= 1'b0;
        end
    end

    // trim strap is caught once, just after reset release, then frozen
    logic trim_done_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            trim_done_q    <= 1'b0;
            min_peak_sel_q <= TRIM_RESET;
        end else if (!trim_done_q) begin
            trim_done_q    <= 1'b1;
            min_peak_sel_q <= min_peak_trim;
        end
    end

    // burst gating: stop below the low level, resume above the high level
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            burst_stop_q <= 1'b0;
        end else if (state_q != ST_RUN || fb_res_s) begin
            burst_stop_q <= 1'b0;
        end else if (fb_stop_s) begin
            burst_stop_q <= 1'b1;
        end
    end

    logic [15:0] stby_cnt_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stby_cnt_q <= 16'h0000;
        end else if (!fb_stop_s || state_q != ST_RUN) begin
            stby_cnt_q <= 16'h0000;
        end else if (stby_cnt_q != STANDBY_CYC) begin
            stby_cnt_q <= stby_cnt_q + 16'h0001;
        end
    end

    // count reaching the limit means strictly more than the delay has passed
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            standby_current_q <= 1'b0;
        end else if (state_q != ST_RUN || fb_res_s) begin
            standby_current_q <= 1'b0;
        end else if (fb_stop_s && stby_cnt_q == STANDBY_CYC) begin
            standby_current_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            min_peak_clamp_q <= 1'b0;
        end else begin
            min_peak_clamp_q <= (state_q == ST_RUN) && fb_min_s;
        end
    end

    // switching cycle timers
    logic [5:0]  on_cnt_q;
    logic [15:0] off_cnt_q;
    logic        aux_prev_q;
    logic        aux_rise;
    logic        blank_done;
    logic        pulse_end;
    logic        turn_on;
    logic        run_ok;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aux_prev_q <= 1'b0;
        end else begin
            aux_prev_q <= aux_s;
        end
    end

    assign aux_rise = aux_s & ~aux_prev_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            on_cnt_q <= 6'h00;
        end else if (!gate_drive_q) begin
            on_cnt_q <= 6'h00;
        end else if (on_cnt_q != LEB_CYC) begin
            on_cnt_q <= on_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            off_cnt_q <= 16'h0000;
        end else if (gate_drive_q) begin
            off_cnt_q <= 16'h0000;
        end else if (off_cnt_q != TIMEOUT_CYC) begin
            off_cnt_q <= off_cnt_q + 16'h0001;
        end
    end

    assign blank_done = (on_cnt_q == LEB_CYC);
    // the clamp swaps the feedback peak for the trimmed minimum peak
    assign pulse_end  = (blank_done && ilim_s)
                      || (min_peak_clamp_q ? csmin_s : peak_s);
    // turn on at the aux drop, or at time-out only if the drop already came;
    // a late drop simply stretches the period, which may fall below 21.5 kHz
    assign turn_on    = !burst_stop_q && (aux_rise
                      || (aux_s && off_cnt_q == TIMEOUT_CYC));
    assign run_ok     = (state_q == ST_RUN) && (state_d == ST_RUN);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gate_drive_q <= 1'b0;
        end else if (!run_ok) begin
            gate_drive_q <= 1'b0;
        end else if (gate_drive_q) begin
            gate_drive_q <= !pulse_end;
        end else begin
            gate_drive_q <= turn_on;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    blank_holds_a: assert property (
        gate_drive_q && !blank_done && !peak_s && !csmin_s && run_ok |=> gate_drive_q)
        else $error("gate ended inside the blanking interval");

    turn_on_cause_a: assert property (
        $rose(gate_drive_q) |-> $past(aux_rise)
            || ($past(aux_s) && $past(off_cnt_q) == TIMEOUT_CYC))
        else $error("turn-on without zero secondary current");

    no_early_on_a: assert property (
        $rose(gate_drive_q) && !$past(aux_rise) |-> $past(off_cnt_q) == TIMEOUT_CYC)
        else $error("forced turn-on before the time-out window");

    sample_enter_a: assert property (
        state_q == ST_CHARGE && vdd_on_s && ar_cnt_q == 3'h0
            |=> bulk_sample_enable_q && !hv_start_enable_q)
        else $error("turn-on level did not start bulk sampling");

    brown_in_a: assert property (
        state_q == ST_SAMPLE && !bulk_s |=> state_q == ST_DISCH ##1 !gate_drive_q)
        else $error("switching started below brown-in");

    hv_off_run_a: assert property (
        state_q == ST_RUN |-> !hv_start_enable_q)
        else $error("startup source on while switching");

    burst_gate_a: assert property (
        burst_stop_q |=> !$rose(gate_drive_q))
        else $error("gate pulse while burst stopped");

    standby_exit_a: assert property (
        fb_res_s |=> !standby_current_q && !burst_stop_q)
        else $error("standby not left on resume level");

    standby_delay_a: assert property (
        $rose(standby_current_q) |-> $past(stby_cnt_q) == STANDBY_CYC)
        else $error("standby entered before the delay");

    fault_stop_a: assert property (
        state_q == ST_RUN && fault_ar |=> !gate_drive_q [*2])
        else $error("gate not held off on fault");

    recharge_a: assert property (
        state_q == ST_DISCH && vdd_off_s |=> state_q == ST_CHARGE && hv_start_enable_q)
        else $error("protection not reset at turn-off level");

    multi_ar_a: assert property (
        state_q == ST_RUN && fault_out && high_line_q |=> ar_cnt_q == AR_HIGH_LINE)
        else $error("wrong restart cycle count");

    line_flag_a: assert property (
        cmp_s[IN_LINE_HI] |=> high_line_q)
        else $error("line flag not set above entry current");

endmodule : qfs_sequencer

//--- qfs_power_stage.sv
// behavioural flyback power stage: sense comparators and aux winding
module qfs_power_stage (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       gate_drive_q,
    input  wire logic [7:0] ilim_dly,
    input  wire logic [7:0] peak_dly,
    input  wire logic [7:0] min_dly,
    input  wire logic [7:0] aux_dly,
    output logic            current_limit_cmp,
    output logic            peak_reached_cmp,
    output logic            min_peak_reached_cmp,
    output logic            aux_sense_input
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] on_q;
    logic [7:0] off_q;

    // counters saturate so the aux drop, once shown, stays until the next turn-on
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            on_q  <= 8'h00;
            off_q <= 8'h00;
        end else if (gate_drive_q) begin
            on_q  <= (on_q == 8'hff) ? on_q : on_q + 8'h01;
            off_q <= 8'h00;
        end else begin
            on_q  <= 8'h00;
            off_q <= (off_q == 8'hff) ? off_q : off_q + 8'h01;
        end
    end

    // sense ramp crosses each threshold a fixed time after turn-on
    assign current_limit_cmp    = gate_drive_q && (on_q >= ilim_dly);
    assign peak_reached_cmp     = gate_drive_q && (on_q >= peak_dly);
    assign min_peak_reached_cmp = gate_drive_q && (on_q >= min_dly);
    // aux drop shows only once the secondary current has run out
    assign aux_sense_input      = !gate_drive_q && (off_q >= aux_dly);
endmodule : qfs_power_stage

//--- qfs_sequencer_tb.sv
// self-checking bench for the flyback control sequencer
module qfs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import qfs_pkg::*;

    localparam logic [15:0] TO_CYC = 16'h0028;
    localparam logic [15:0] SB_CYC = 16'h0014;

    logic       clk_sys, resetn, vdd_on, vdd_off, bulk_ok, fb_stop, fb_res, fb_min;
    logic       line_hi, line_lo, ilim_c, peak_c, min_c, aux_c, gate_prev;
    logic       gate, hv, samp, clamp, stby, hl, bstop, prot;
    logic [4:0] flt;
    logic [1:0] trim, sel;
    logic [7:0] ilim_dly, peak_dly, min_dly, aux_dly;
    int         n_fail, n_compared, n_samp, n_rise;

    qfs_sequencer #(.TIMEOUT_CYC(TO_CYC), .STANDBY_CYC(SB_CYC)) qfs_sequencer_inst (
        .clk_sys(clk_sys), .resetn(resetn), .current_limit_cmp(ilim_c),
        .peak_reached_cmp(peak_c), .min_peak_reached_cmp(min_c), .aux_sense_input(aux_c),
        .supply_turn_on_level(vdd_on), .supply_turn_off_level(vdd_off),
        .bulk_above_brown_in(bulk_ok), .burst_stop_level(fb_stop),
        .burst_resume_level(fb_res), .fb_below_min_peak(fb_min),
        .supply_overvoltage_fault(flt[0]), .abnormal_overcurrent_fault(flt[1]),
        .thermal_shutdown_fault(flt[2]), .output_overvoltage_fault(flt[3]),
        .output_undervoltage_fault(flt[4]), .high_line_entry_current(line_hi),
        .low_line_entry_current(line_lo), .min_peak_trim(trim), .gate_drive_q(gate),
        .hv_start_enable_q(hv), .bulk_sample_enable_q(samp), .min_peak_clamp_q(clamp),
        .min_peak_sel_q(sel), .standby_current_q(stby), .high_line_q(hl),
        .burst_stop_q(bstop), .protect_active_q(prot));

    qfs_power_stage qfs_power_stage_inst (
        .clk_sys(clk_sys), .resetn(resetn), .gate_drive_q(gate), .ilim_dly(ilim_dly),
        .peak_dly(peak_dly), .min_dly(min_dly), .aux_dly(aux_dly),
        .current_limit_cmp(ilim_c), .peak_reached_cmp(peak_c),
        .min_peak_reached_cmp(min_c), .aux_sense_input(aux_c));

    always #4 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        gate_prev <= gate;
        if (samp === 1'b1) n_samp++;
        if (gate === 1'b1 && gate_prev === 1'b0) n_rise++;
    end

    task stop_test;
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task in_rng(input int v, input int lo, input int hi, input string what);
        chk(16'(v >= lo && v <= hi), 16'h0001, what);
    endtask : in_rng

    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    // bounded so a stuck gate shows up as an out-of-range count
    task wait_gate(input logic lvl, output int n);
        n = 0;
        while (gate !== lvl && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
    endtask : wait_gate

    task pulse(output int hi, output int lo);
        int n;
        wait_gate(1'b0, n);
        wait_gate(1'b1, n);
        wait_gate(1'b0, hi);
        wait_gate(1'b1, lo);
    endtask : pulse

    task set_ps(input logic [7:0] i, input logic [7:0] p, input logic [7:0] m,
                input logic [7:0] a);
        @(posedge clk_sys);
        ilim_dly <= i;
        peak_dly <= p;
        min_dly  <= m;
        aux_dly  <= a;
    endtask : set_ps

    task supply_cycle(output logic sampled);
        int s0, k;
        s0 = n_samp;
        @(posedge clk_sys);
        vdd_on  <= 1'b0;
        vdd_off <= 1'b1;
        for (k = 0; k < 20 && hv !== 1'b1; k++) cyc(1);
        chk(hv, 1, "startup source on at turn-off level");
        chk(prot, 0, "protection cleared");
        @(posedge clk_sys);
        vdd_off <= 1'b0;
        vdd_on  <= 1'b1;
        cyc(12);
        chk(hv, 0, "startup source off at turn-on level");
        sampled = (n_samp != s0);
    endtask : supply_cycle

    task t_startup;
        int k;
        logic s;
        chk(hv, 1, "startup source after reset");
        chk({gate, samp, clamp, stby, hl, bstop, prot}, 0, "outputs after reset");
        chk(sel, 2'h2, "trim latched");
        @(posedge clk_sys);
        vdd_on <= 1'b1;
        for (k = 0; k < 20 && prot !== 1'b1; k++) cyc(1);
        chk(prot, 1, "auto-restart below brown-in");
        chk(16'(n_samp), 16'h0001, "bulk sampled once");
        chk(16'(n_rise), 16'h0000, "no switching below brown-in");
        chk(hv, 0, "startup source off");
        @(posedge clk_sys);
        bulk_ok <= 1'b1;
        supply_cycle(s);
        chk(s, 1, "bulk sampled again");
        wait_gate(1'b1, k);
        in_rng(k, 0, 2999, "switching starts above brown-in");
        chk(hv, 0, "startup source off while switching");
    endtask : t_startup

    task turn_on_blank_time;
        int h, l;
        set_ps(8'h01, 8'hff, 8'hff, 8'h04);
        pulse(h, l);
        pulse(h, l);
        in_rng(h, int'(LEB_CYC), int'(LEB_CYC) + 8, "current limit blanked");
        chk(hv, 0, "startup source stays off");
    endtask : turn_on_blank_time

    task t_ccm;
        int h, l;
        set_ps(8'h01, 8'hff, 8'hff, 8'h64);
        pulse(h, l);
        pulse(h, l);
        in_rng(l, 100, 108, "turn-on waits past time-out for aux drop");
        set_ps(8'h01, 8'hff, 8'hff, 8'h04);
        pulse(h, l);
        pulse(h, l);
        in_rng(l, 4, 12, "turn-on follows aux drop");
    endtask : t_ccm

    task t_clamp;
        int h, l;
        set_ps(8'hff, 8'h50, 8'h32, 8'h04);
        @(posedge clk_sys);
        fb_min <= 1'b1;
        trim   <= 2'h1;
        pulse(h, l);
        pulse(h, l);
        chk(clamp, 1, "minimum peak clamp on");
        in_rng(h, 50, 58, "pulse ends at minimum peak");
        chk(sel, 2'h2, "trim ignores runtime change");
        @(posedge clk_sys);
        fb_min <= 1'b0;
        pulse(h, l);
        pulse(h, l);
        chk(clamp, 0, "minimum peak clamp off");
        in_rng(h, 80, 88, "pulse ends at feedback peak");
    endtask : t_clamp

    task t_burst;
        int k, r0;
        set_ps(8'h01, 8'hff, 8'hff, 8'h04);
        @(posedge clk_sys);
        fb_stop <= 1'b1;
        for (k = 0; k < 10 && bstop !== 1'b1; k++) cyc(1);
        chk(bstop, 1, "burst stop entered");
        cyc(2);
        r0 = n_rise;
        cyc(12);
        chk(stby, 0, "standby not before delay");
        cyc(14);
        chk(stby, 1, "standby after delay");
        chk(16'(n_rise - r0), 16'h0000, "no pulses while stopped");
        @(posedge clk_sys);
        fb_stop <= 1'b0;
        fb_res  <= 1'b1;
        for (k = 0; k < 10 && bstop !== 1'b0; k++) cyc(1);
        chk(bstop, 0, "burst resume");
        chk(stby, 0, "normal current restored");
        wait_gate(1'b1, k);
        in_rng(k, 0, 60, "switching resumes");
        @(posedge clk_sys);
        fb_res <= 1'b0;
    endtask : t_burst

    task ar_fault(input int idx, input int exp_n);
        int k, n;
        logic s;
        wait_gate(1'b1, n);
        @(posedge clk_sys);
        flt[idx] <= 1'b1;
        for (k = 0; k < 12 && prot !== 1'b1; k++) cyc(1);
        chk(prot, 1, "auto-restart entered");
        chk(gate, 0, "gate off on fault");
        @(posedge clk_sys);
        flt[idx] <= 1'b0;
        r_hold: for (k = 0; k < 40; k++) begin
            cyc(1);
            if (gate !== 1'b0) break;
        end
        chk(gate, 0, "gate held off while discharging");
        n = 0;
        s = 1'b0;
        while (!s && n < 8) begin
            supply_cycle(s);
            n++;
        end
        chk(16'(n), 16'(exp_n), "restart cycles before sampling");
        wait_gate(1'b1, k);
        in_rng(k, 0, 2999, "normal operation resumes");
    endtask : ar_fault

    task t_line;
        @(posedge clk_sys);
        line_hi <= 1'b1;
        cyc(10);
        chk(hl, 1, "high line selected");
        @(posedge clk_sys);
        line_hi <= 1'b0;
        cyc(10);
        chk(hl, 1, "high line held between levels");
        ar_fault(3, 6);
        @(posedge clk_sys);
        line_lo <= 1'b1;
        cyc(10);
        @(posedge clk_sys);
        line_lo <= 1'b0;
        cyc(10);
        chk(hl, 0, "low line held between levels");
        ar_fault(4, 3);
    endtask : t_line

    initial begin
        clk_sys = 1'b0;
        resetn  = 1'b0;
        {vdd_on, vdd_off, bulk_ok, fb_stop, fb_res, fb_min, line_hi, line_lo} = 8'h00;
        flt      = 5'h00;
        trim     = 2'h2;
        ilim_dly = 8'h01;
        peak_dly = 8'hff;
        min_dly  = 8'hff;
        aux_dly  = 8'h04;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        cyc(2);
        t_startup();
        turn_on_blank_time();
        t_ccm();
        t_clamp();
        t_burst();
        for (int i = 0; i < 3; i++) ar_fault(i, 1);
        t_line();
        stop_test();
    end

    // whole run needs a few thousand cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end
endmodule : qfs_sequencer_tb
